// file: logic/ext_mem_bus.sv
// What this block does
// - Bus is always sixteen bits wide
// - Disable bit set hands pins to ports in mixed modes
// - External-only mode keeps bus always active
// - Internal-only mode: ports only, control writes blocked
// - Mixed modes: external accesses take bus
// - Mixed modes internal: disable bit picks function
// - Wait code 11/10/01/00 adds 0/1/2/3 cycles to reads and writes
// - Word write: upper strobe on odd byte
// - Byte select: both halves, upper strobe, lane
// - Byte write: both halves, one strobe
// - External access overrides disable bit
// - Disable takes effect after branch internal
// - Idle enabled bus tri-states address/data lines
// - Idle control levels high, latch/select low
// - Data bits on first two ports
// - Upper address bits on third port
// - Control signals on fourth port order
// - Control resets zero, unused bits read zero
// - Port function whenever bus not selected
// - Latch marks address; output enable reads word
// - Chip enable low in access, high asleep
// - Even word write only latches, floats bus
// - Pointer bit zero picks byte-write strobe
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ext_mem_bus
   import ext_mem_pkg::*;
(
   // Clock and reset
   input  wire  logic                   clock,
   input  wire  logic                   rst_n,
   // Configuration
   input  wire  ext_mem_pkg::mem_mode_t memMode,
   input  wire  logic                   sleepMode,
   // Register port
   input  wire  logic [3:0]             regAddr,
   input  wire  logic [7:0]             regWdata,
   input  wire  logic                   regWr,
   input  wire  logic                   regRd,
   output logic [7:0]                   regRdata,
   // Core request and answer
   input  wire  ext_mem_pkg::core_req_t coreReq,
   output logic                         coreStall,
   output logic                         coreDone,
   output logic [15:0]                  coreRdata,
   // Port-side values when pins are ports
   input  wire  logic [7:0]             portDOut,
   input  wire  logic [7:0]             portDOe,
   input  wire  logic [7:0]             portEOut,
   input  wire  logic [7:0]             portEOe,
   input  wire  logic [3:0]             portHOut,
   input  wire  logic [3:0]             portHOe,
   input  wire  logic [7:0]             portJOut,
   input  wire  logic [7:0]             portJOe,
   // Pins
   input  wire  logic [7:0]             pinDIn,
   input  wire  logic [7:0]             pinEIn,
   output logic [7:0]                   pinDOut,
   output logic [7:0]                   pinDOe,
   output logic [7:0]                   pinEOut,
   output logic [7:0]                   pinEOe,
   output logic [3:0]                   pinHOut,
   output logic [3:0]                   pinHOe,
   output logic [7:0]                   pinJOut,
   output logic [7:0]                   pinJOe,
   output logic                         busActive
);
   import ext_mem_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_DATA = 4'b0100,
      ST_WAIT = 4'b1000
   } bus_state_t;

   typedef struct packed {
      bus_state_t  st;
      logic [7:0]  ctrlReg;
      logic        pendDisable;
      logic [1:0]  waitCnt;
      core_req_t   cur;
      logic [7:0]  holdLatch;
      logic [15:0] adOut;
      logic        adOe;
      ctrl_pins_t  ctl;
      logic [15:0] rdata;
      logic        done;
      logic [7:0]  regRdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // Wait code maps inversely to added cycles
   function automatic logic [1:0] waitCycles(input logic [1:0] code);
      waitCycles = ~code;
   endfunction

   logic mixedMode;
   logic busOwn;
   logic effDisable;
   logic [1:0] scheme;
   logic oddByte;

   always_comb begin
      mixedMode  = (memMode == MODE_BOOT_MIX) || (memMode == MODE_EXT_MIX);
      effDisable = s_r.ctrlReg[BUS_DISABLE_BIT] & ~s_r.pendDisable;
      scheme     = s_r.ctrlReg[SCHEME_HI_BIT:SCHEME_LO_BIT];
      oddByte    = s_r.cur.addr[0];
      // Active access keeps pins as bus regardless of the disable bit
      if (memMode == MODE_EXT_ONLY)
         busOwn = 1'b1;
      else if (mixedMode)
         busOwn = (s_r.st != ST_IDLE) || !effDisable;
      else
         busOwn = 1'b0;
   end

   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      s_nxt.regRdata = 8'h00;
      if (regRd) begin
         case (regAddr)
            MEM_IF_CTRL_OFFSET: s_nxt.regRdata = s_r.ctrlReg & MEM_IF_CTRL_MASK;
            BUS_STATUS_OFFSET:  s_nxt.regRdata = {4'h0, s_r.st};
            default:            s_nxt.regRdata = 8'h00;
         endcase
      end
      if (regWr && regAddr == MEM_IF_CTRL_OFFSET && memMode != MODE_INT_ONLY) begin
         s_nxt.ctrlReg = regWdata & MEM_IF_CTRL_MASK;
         // Setting disable while running externally waits for an internal branch
         if (regWdata[BUS_DISABLE_BIT] && !s_r.ctrlReg[BUS_DISABLE_BIT])
            s_nxt.pendDisable = coreReq.external;
      end
      if (coreReq.req && !coreReq.external && coreReq.kind == ACC_FETCH)
         s_nxt.pendDisable = 1'b0;
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.adOe = 1'b0;
            s_nxt.ctl  = CTRL_IDLE;
            if (coreReq.req && coreReq.external && memMode != MODE_INT_ONLY) begin
               s_nxt.cur = coreReq;
               s_nxt.st  = ST_ADDR;
               s_nxt.adOut = coreReq.addr[15:0];
               s_nxt.adOe  = 1'b1;
               s_nxt.ctl.addrLatch    = 1'b1;
               s_nxt.ctl.chipEnable_n = sleepMode;
               s_nxt.ctl.byteLaneSelect = coreReq.addr[0];
            end
         end
         ST_ADDR: begin
            s_nxt.ctl.addrLatch = 1'b0;
            s_nxt.waitCnt = (s_r.cur.kind == ACC_FETCH) ? 2'h0 :
                            waitCycles(s_r.ctrlReg[WAIT_HI_BIT:WAIT_LO_BIT]);
            s_nxt.st = ST_DATA;
            if (s_r.cur.kind != ACC_WRITE) begin
               s_nxt.adOe = 1'b0;
               s_nxt.ctl.outputEnable_n = 1'b0;
            end else if (scheme[1]) begin
               if (!oddByte) begin
                  s_nxt.holdLatch = s_r.cur.wdata;
                  s_nxt.adOe = 1'b0;
               end else begin
                  s_nxt.adOut = {s_r.cur.wdata, s_r.holdLatch};
                  s_nxt.ctl.upperWriteStrobe = 1'b0;
                  s_nxt.ctl.upperLaneEnable  = 1'b0;
                  s_nxt.ctl.lowerLaneEnable  = 1'b0;
               end
            end else begin
               s_nxt.adOut = {s_r.cur.wdata, s_r.cur.wdata};
               if (scheme[0]) begin
                  s_nxt.ctl.upperWriteStrobe = 1'b0;
                  s_nxt.ctl.upperLaneEnable  = !oddByte;
                  s_nxt.ctl.lowerLaneEnable  = oddByte;
               end else if (oddByte)
                  s_nxt.ctl.upperWriteStrobe = 1'b0;
               else
                  s_nxt.ctl.lowerWriteStrobe = 1'b0;
            end
         end
         ST_DATA, ST_WAIT: begin
            // Bus held steady while waits run down
            if (s_r.waitCnt != 2'h0) begin
               s_nxt.waitCnt = s_r.waitCnt - 2'h1;
               s_nxt.st = ST_WAIT;
            end else begin
               s_nxt.rdata = {pinEIn, pinDIn};
               s_nxt.done  = 1'b1;
               s_nxt.st    = ST_IDLE;
               s_nxt.adOe  = 1'b0;
               s_nxt.ctl   = CTRL_IDLE;
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
      if (!rst_n) begin
         s_nxt = '0;
         s_nxt.st = ST_IDLE;
         s_nxt.ctrlReg = MEM_IF_CTRL_RESET;
         s_nxt.ctl = CTRL_IDLE;
      end
   end

   always_ff @(posedge clock) begin
      s_r <= s_nxt;
   end

   always_comb begin
      coreStall = (s_r.st != ST_IDLE) && !s_nxt.done;
      coreDone  = s_r.done;
      coreRdata = s_r.rdata;
      regRdata  = s_r.regRdata;
      busActive = busOwn;
      if (busOwn) begin
         pinDOut = s_r.adOut[7:0];
         pinEOut = s_r.adOut[15:8];
         pinDOe  = {8{s_r.adOe}};
         pinEOe  = {8{s_r.adOe}};
         pinHOut = s_r.cur.addr[19:16];
         pinHOe  = {4{s_r.st != ST_IDLE}};
         pinJOut = s_r.ctl;
         pinJOe  = 8'hFF;
      end else begin
         pinDOut = portDOut;
         pinDOe  = portDOe;
         pinEOut = portEOut;
         pinEOe  = portEOe;
         pinHOut = portHOut;
         pinHOe  = portHOe;
         pinJOut = portJOut;
         pinJOe  = portJOe;
      end
   end
endmodule
`default_nettype wire

// file: logic/ext_mem_pkg.sv
`default_nettype none
package ext_mem_pkg;

   // Register map (offset index on the plain register port)
   localparam logic [3:0] MEM_IF_CTRL_OFFSET = 4'h0;
   localparam logic [3:0] BUS_STATUS_OFFSET  = 4'h1;
   localparam logic [7:0] MEM_IF_CTRL_RESET  = 8'h00;
   localparam logic [7:0] MEM_IF_CTRL_MASK   = 8'hB3;

   // Field positions of memory_interface_control
   localparam int BUS_DISABLE_BIT = 7;
   localparam int WAIT_HI_BIT     = 5;
   localparam int WAIT_LO_BIT     = 4;
   localparam int SCHEME_HI_BIT   = 1;
   localparam int SCHEME_LO_BIT   = 0;

   // Phase lengths in cycles
   localparam logic [1:0] ADDR_CYCLES = 2'h1;

   typedef enum logic [1:0] {
      MODE_EXT_ONLY  = 2'h0,
      MODE_BOOT_MIX  = 2'h1,
      MODE_EXT_MIX   = 2'h2,
      MODE_INT_ONLY  = 2'h3
   } mem_mode_t;

   typedef enum logic [1:0] {
      ACC_FETCH = 2'h0,
      ACC_READ  = 2'h1,
      ACC_WRITE = 2'h2
   } acc_kind_t;

   // Control pins in port order, bit 7 first
   typedef struct packed {
      logic upperLaneEnable;
      logic lowerLaneEnable;
      logic chipEnable_n;
      logic byteLaneSelect;
      logic upperWriteStrobe;
      logic lowerWriteStrobe;
      logic outputEnable_n;
      logic addrLatch;
   } ctrl_pins_t;

   localparam ctrl_pins_t CTRL_IDLE = '{upperLaneEnable: 1'b1, lowerLaneEnable: 1'b1,
      chipEnable_n: 1'b1, byteLaneSelect: 1'b0, upperWriteStrobe: 1'b1,
      lowerWriteStrobe: 1'b1, outputEnable_n: 1'b1, addrLatch: 1'b0};

   typedef struct packed {
      logic        req;
      acc_kind_t   kind;
      logic        external;
      logic [19:0] addr;
      logic [7:0]  wdata;
   } core_req_t;

endpackage
`default_nettype wire

// file: tb/ext_mem_bus_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ext_mem_checker
   import ext_mem_pkg::*;
(
   // Clock and reset
   input wire logic                   clock,
   input wire logic                   rst_n,
   // Watched ports
   input wire ext_mem_pkg::mem_mode_t memMode,
   input wire logic                   sleepMode,
   input wire logic [3:0]             regAddr,
   input wire logic                   regRd,
   input wire logic [7:0]             regRdata,
   input wire ext_mem_pkg::core_req_t coreReq,
   input wire logic                   coreDone,
   input wire logic                   coreStall,
   input wire logic [7:0]             portJOut,
   input wire logic [7:0]             portJOe,
   input wire logic [7:0]             pinDOe,
   input wire logic [3:0]             pinHOe,
   input wire logic [7:0]             pinJOut,
   input wire logic [7:0]             pinJOe,
   input wire logic                   busActive
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic busyR;
   logic take;
   // Own busy view, so a request refused by the design never starts a latency count
   assign take = coreReq.req && coreReq.external && memMode != MODE_INT_ONLY && !busyR;
   always_ff @(posedge clock) begin
      busyR <= rst_n && (take || (busyR && !coreDone));
   end
   AST_ALE_CE: assert property (take && !sleepMode |=> pinJOut[0] && !pinJOut[5] && busActive)
      else $error("address latch or chip enable wrong after accept");
   AST_SLEEP_CE: assert property (take && sleepMode |=> pinJOut[5] [*3])
      else $error("chip enable active while asleep");
   AST_FETCH: assert property (take && coreReq.kind == ACC_FETCH |-> !coreDone [*3] ##1 coreDone)
      else $error("fetch did not end three cycles after accept");
   AST_STALL: assert property (take && coreReq.kind == ACC_FETCH |=> coreStall ##1 !coreStall)
      else $error("core stall not high for exactly the address cycle of a fetch");
   AST_STALL_END: assert property (coreDone |-> !coreStall)
      else $error("core still stalled when access completes");
   AST_IDLE: assert property (busActive && !busyR |-> pinJOut == CTRL_IDLE && pinDOe == 8'h00 && pinHOe == 4'h0)
      else $error("idle bus pins not at rest levels");
   AST_INT: assert property (memMode == MODE_INT_ONLY |-> !busActive)
      else $error("bus active in internal-only mode");
   AST_EXT: assert property (memMode == MODE_EXT_ONLY |-> busActive)
      else $error("bus inactive in external-only mode");
   AST_PORT: assert property (!busActive |-> pinJOut == portJOut && pinJOe == portJOe)
      else $error("port values not on pins");
   AST_UNUSED: assert property (regRd && regAddr == MEM_IF_CTRL_OFFSET |=> (regRdata & 8'h4C) == 8'h00)
      else $error("unimplemented control bits read nonzero");
endmodule
bind ext_mem_bus ext_mem_checker u_chk (.clock, .rst_n, .memMode, .sleepMode, .regAddr, .regRd, .regRdata,
   .coreReq, .coreDone, .coreStall, .portJOut, .portJOe, .pinDOe, .pinHOe, .pinJOut, .pinJOe, .busActive);
`default_nettype wire

// file: tb/ext_mem_bus_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ext_mem_bus_bench;
   import ext_mem_pkg::*;
   logic        clock, rst_n, sleepMode, regWr, regRd, coreStall, coreDone, busActive;
   mem_mode_t   memMode;
   core_req_t   coreReq;
   logic [3:0]  regAddr, portHOut, portHOe, pinHOut, pinHOe;
   logic [7:0]  regWdata, regRdata, portDOut, portDOe, portEOut, portEOe, portJOut, portJOe, v;
   logic [7:0]  pinDIn, pinEIn, pinDOut, pinDOe, pinEOut, pinEOe, pinJOut, pinJOe;
   logic [15:0] coreRdata, memRd, q;
   int          n, failCount, checkCount;
   ext_mem_bus u_dut (.*);
   ext_mem_model u_mem (.clock, .adLo(pinDOut), .adHi(pinEOut), .addrUp(pinHOut),
      .ctrl(ctrl_pins_t'(pinJOut)), .rdData(memRd));
   assign pinDIn = (pinDOut & pinDOe) | (memRd[7:0] & ~pinDOe);
   assign pinEIn = (pinEOut & pinEOe) | (memRd[15:8] & ~pinEOe);
   always #5 clock = ~clock;
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finalReport;
      $display("Comparisons %0d, mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic rst(input mem_mode_t m);
      rst_n <= 1'b0;
      memMode <= m;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      @(negedge clock);
      v = regRdata;
      @(posedge clock);
   endtask
   task automatic seeBus(input logic e);
      @(negedge clock);
      check("busActive", {15'h0000, busActive}, {15'h0000, e});
      @(posedge clock);
   endtask
   task automatic acc(input acc_kind_t k, input logic [19:0] a, input logic [7:0] d);
      coreReq <= '{1'b1, k, 1'b1, a, d};
      @(posedge clock);
      coreReq.req <= 1'b0;
      @(negedge clock);
      check("upper address", {12'h000, pinHOut}, {12'h000, a[19:16]});
      check("address phase", {pinEOut, pinDOut}, a[15:0]);
      for (n = 0; coreDone !== 1'b1 && n < 20; n++) @(negedge clock);
      q = coreRdata;
      if (n == 20) begin
         failCount++;
         finalReport();
      end
      @(posedge clock);
   endtask
   // Internal fetch: no bus cycle, but it marks a branch into internal memory
   task automatic intFetch(input logic [19:0] a);
      coreReq <= '{1'b1, ACC_FETCH, 1'b0, a, 8'h00};
      @(posedge clock);
      coreReq.req <= 1'b0;
   endtask
   task automatic regsTest;
      rd(MEM_IF_CTRL_OFFSET);
      check("ctrl reset", {8'h00, v}, 16'h0000);
      wr(MEM_IF_CTRL_OFFSET, 8'hFF);
      rd(MEM_IF_CTRL_OFFSET);
      check("ctrl mask", {8'h00, v}, 16'h00B3);
      rd(4'h7);
      check("unmapped", {8'h00, v}, 16'h0000);
      seeBus(1'b1);
   endtask
   task automatic waitTest;
      for (int c = 0; c < 4; c++) begin
         wr(MEM_IF_CTRL_OFFSET, 8'(c << 4));
         acc(ACC_READ, 20'hA0010, 8'h00);
         check("read cycles", 16'(n), 16'(ADDR_CYCLES) + 16'(4 - c));
         acc(ACC_FETCH, 20'h50012, 8'h00);
         check("fetch cycles", 16'(n), 16'(ADDR_CYCLES) + 16'h0001);
      end
   endtask
   task automatic pair(input logic [7:0] cfg, input logic [19:0] a, input logic [7:0] d0, input logic [7:0] d1,
                       input logic [15:0] mid, input logic [15:0] fin);
      wr(MEM_IF_CTRL_OFFSET, cfg);
      acc(ACC_WRITE, a, d0);
      acc(ACC_READ, a, 8'h00);
      check("first byte", q, mid);
      acc(ACC_WRITE, a | 20'h00001, d1);
      acc(ACC_READ, a, 8'h00);
      check("word", q, fin);
   endtask
   task automatic writeTest;
      pair(8'h32, 20'h30010, 8'hA5, 8'h5A, 16'h0000, 16'h5AA5);
      pair(8'h30, 20'hC0020, 8'h3C, 8'hC3, 16'h003C, 16'hC33C);
      pair(8'h31, 20'h00036, 8'h88, 8'h77, 16'h0088, 16'h7788);
   endtask
   task automatic disableTest;
      // Core still runs from external memory when it sets the disable bit
      coreReq.external <= 1'b1;
      wr(MEM_IF_CTRL_OFFSET, 8'hB3);
      seeBus(1'b1);
      intFetch(20'h00200);
      seeBus(1'b0);
      acc(ACC_READ, 20'h00010, 8'h00);
      check("disabled read", q, 16'h5AA5);
      sleepMode <= 1'b1;
      acc(ACC_FETCH, 20'h00010, 8'h00);
      sleepMode <= 1'b0;
      wr(MEM_IF_CTRL_OFFSET, 8'h33);
      seeBus(1'b1);
   endtask
   task automatic intOnlyTest;
      portJOut <= 8'h96;
      portJOe <= 8'h0F;
      wr(MEM_IF_CTRL_OFFSET, 8'h80);
      rd(MEM_IF_CTRL_OFFSET);
      check("blocked write", {8'h00, v}, 16'h0000);
      seeBus(1'b0);
   endtask
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      memMode = MODE_EXT_ONLY;
      coreReq = '0;
      {regAddr, regWdata, regWr, regRd, sleepMode} = '0;
      {portDOut, portDOe, portEOut, portEOe, portHOut, portHOe, portJOut, portJOe} = '1;
      rst(MODE_EXT_ONLY);
      regsTest();
      waitTest();
      writeTest();
      rst(MODE_EXT_MIX);
      disableTest();
      rst(MODE_INT_ONLY);
      intOnlyTest();
      finalReport();
   end
endmodule
`default_nettype wire

// file: tb/ext_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
   // Bus pins
   input  wire logic                    clock,
   input  wire logic [7:0]              adLo,
   input  wire logic [7:0]              adHi,
   input  wire logic [3:0]              addrUp,
   input  wire ext_mem_pkg::ctrl_pins_t ctrl,
   // Data back towards the pins
   output logic [15:0]                  rdData
);
   logic [19:0] addrR;
   logic [15:0] mem [0:15];
   initial foreach (mem[i]) mem[i] = 16'h0000;
   // Undriven bus shows the inverse, so a read that misses the enable cannot match
   assign rdData = (!ctrl.chipEnable_n && !ctrl.outputEnable_n) ? mem[addrR[4:1]] : ~mem[addrR[4:1]];
   always @(posedge clock) begin
      if (ctrl.addrLatch) begin
         addrR <= {addrUp, adHi, adLo};
      end
      if (!ctrl.chipEnable_n && !ctrl.upperWriteStrobe && (!ctrl.upperLaneEnable || ctrl.lowerLaneEnable)) begin
         mem[addrR[4:1]][15:8] <= adHi;
      end
      if (!ctrl.chipEnable_n && (!ctrl.lowerWriteStrobe || (!ctrl.upperWriteStrobe && !ctrl.lowerLaneEnable))) begin
         mem[addrR[4:1]][7:0] <= adLo;
      end
   end
endmodule
`default_nettype wire
